// File: logic/diff_eval.sv
// Purpose: distance difference evaluator with five modes and APB registers
// Assumes: sample_valid marks a new distance sample on pclk
// Notes: sync pin is external and double synchronised
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module diff_eval
  import diff_eval_pkg::*;
#(
  parameter int unsigned WIN_CYC = WINDOW_CYC,
  parameter int unsigned PULSE_LEN = PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] sample,
  input wire logic sample_valid,
  input wire logic sync_in,
  output logic switch_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ---------------------------------------------------------------
  // sync pin synchroniser
  // ---------------------------------------------------------------
  logic sync_m_q, sync_s_q, sync_p_q; // meta, stable, previous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_p_q <= 1'b0;
    end else begin
      sync_m_q <= sync_in;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
    end
  end
  wire sync_rise = sync_s_q && !sync_p_q;
  wire sync_fall = !sync_s_q && sync_p_q;

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic [2:0] mode_q, mode_d; // selected evaluation mode
  logic [15:0] ta_q, ta_d; // teach value a
  logic [15:0] tb_q, tb_d; // teach value b
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [15:0] diff_q; // last computed difference
  logic [15:0] last_q; // last sample
  logic teach_err; // taught value below minimum
  logic mapped;

  // address decode shared by reads and writes
  always_comb begin
    mapped = (paddr == REG_MODE) || (paddr == REG_TEACH_A) || (paddr == REG_TEACH_B) ||
             (paddr == REG_STATUS) || (paddr == REG_RESULT) || (paddr == REG_SAMPLE);
  end

  // minimum teach checks per mode
  always_comb begin
    case (mode_t'(mode_q))
      MODE_STEP: teach_err = ta_q < MIN_STEP_UM;
      MODE_WIN: teach_err = (ta_q < tb_q) || ((ta_q - tb_q) < MIN_WIN_UM);
      MODE_TWOPT: teach_err = ta_q < MIN_DEV_UM;
      default: teach_err = 1'b0;
    endcase
  end

  // next values for bus state; answers two cycles after setup, one wait state
  always_comb begin
    mode_d = mode_q;
    ta_d = ta_q;
    tb_d = tb_q;
    prdata_d = 32'h0000_0000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready) begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
      if (pwrite) begin
        case (paddr)
          REG_MODE: begin
            // only defined codes are kept, one mode at a time
            if (pwdata[2:0] <= 3'h4) begin
              mode_d = pwdata[2:0];
            end
          end
          REG_TEACH_A: ta_d = pwdata[15:0];
          REG_TEACH_B: tb_d = pwdata[15:0];
          default: ;
        endcase
      end else begin
        case (paddr)
          REG_MODE: prdata_d = {29'h0, mode_q};
          REG_TEACH_A: prdata_d = {16'h0, ta_q};
          REG_TEACH_B: prdata_d = {16'h0, tb_q};
          REG_STATUS: prdata_d = {30'h0, teach_err, switch_out};
          REG_RESULT: prdata_d = {16'h0, diff_q};
          REG_SAMPLE: prdata_d = {16'h0, last_q};
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
      ta_q <= TEACH_A_RST;
      tb_q <= TEACH_B_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ta_q <= ta_d;
      tb_q <= tb_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // evaluation state
  // ---------------------------------------------------------------
  logic [15:0] ref_q, ref_d; // step window reference sample
  logic [31:0] wcnt_q, wcnt_d; // step window cycles left
  logic [15:0] mx_q, mx_d, mn_q, mn_d; // min/max trackers
  logic have_q, have_d; // min/max saw a sample
  logic [15:0] p1_q, p1_d; // first two-point capture
  logic lvl_q, lvl_d; // evaluated output level
  logic [15:0] diff_d, last_d;
  logic step_trig; // step pulse request
  logic [15:0] step_chg;
  logic [15:0] half_step;
  logic [15:0] tol_lo, tol_hi;
  logic step_out;

  always_comb begin
    step_chg = absdiff(sample, ref_q);
    half_step = {1'b0, ta_q[15:1]};
    tol_lo = (ta_q > tb_q) ? (ta_q - tb_q) : 16'h0000;
    tol_hi = (ta_q > (16'hFFFF - tb_q)) ? 16'hFFFF : (ta_q + tb_q);
  end

  // mode evaluation next state
  always_comb begin
    ref_d = ref_q;
    wcnt_d = wcnt_q;
    mx_d = mx_q;
    mn_d = mn_q;
    have_d = have_q;
    p1_d = p1_q;
    lvl_d = lvl_q;
    diff_d = diff_q;
    last_d = last_q;
    step_trig = 1'b0;
    if (sample_valid) begin
      last_d = sample;
    end
    case (mode_t'(mode_q))
      MODE_STEP: begin
        lvl_d = 1'b0;
        if (wcnt_q != 32'd0) begin
          wcnt_d = wcnt_q - 32'd1;
        end
        if (sample_valid) begin
          // both rising and falling height change count
          diff_d = step_chg;
          if (step_chg > half_step) begin
            step_trig = 1'b1;
          end
          // window expiry restarts reference; small drift is absorbed
          if (wcnt_q == 32'd0 || step_trig) begin
            ref_d = sample;
            wcnt_d = WIN_CYC - 32'd1;
          end
        end
      end
      MODE_MINMAX: begin
        if (sync_rise) begin
          lvl_d = 1'b0;
          have_d = 1'b0;
        end else if (sync_s_q && sample_valid) begin
          // collect only inside the controller's sequence
          have_d = 1'b1;
          mx_d = (!have_q || sample > mx_q) ? sample : mx_q;
          mn_d = (!have_q || sample < mn_q) ? sample : mn_q;
        end else if (sync_fall && have_q) begin
          diff_d = mx_q - mn_q;
          lvl_d = (mx_q - mn_q) > ta_q;
        end
      end
      MODE_TOL: begin
        if (sample_valid) begin
          // active inside band; polarity unconfirmed, inside taken
          lvl_d = (sample >= tol_lo) && (sample <= tol_hi);
          diff_d = absdiff(sample, ta_q);
        end
      end
      MODE_WIN: begin
        if (sample_valid) begin
          lvl_d = (sample > ta_q) || (sample < tb_q);
        end
      end
      MODE_TWOPT: begin
        if (sync_rise) begin
          p1_d = last_q;
        end else if (sync_fall) begin
          diff_d = absdiff(last_q, p1_q);
          lvl_d = absdiff(last_q, p1_q) > ta_q;
        end
      end
      default: lvl_d = 1'b0;
    endcase
  end

  // evaluation registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 16'h0000;
      wcnt_q <= 32'd0;
      mx_q <= 16'h0000;
      mn_q <= 16'h0000;
      have_q <= 1'b0;
      p1_q <= 16'h0000;
      lvl_q <= 1'b0;
      diff_q <= 16'h0000;
      last_q <= 16'h0000;
    end else begin
      ref_q <= ref_d;
      wcnt_q <= wcnt_d;
      mx_q <= mx_d;
      mn_q <= mn_d;
      have_q <= have_d;
      p1_q <= p1_d;
      lvl_q <= lvl_d;
      diff_q <= diff_d;
      last_q <= last_d;
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  // step pulses are stretched so a slow controller still sees them
  pulse_stretch #(.CYCLES(PULSE_LEN)) u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .trig(step_trig && (mode_q == 3'h0)),
    .out_q(step_out)
  );

  // output register, off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_out <= 1'b0;
    end else begin
      switch_out <= (mode_q == 3'h0) ? step_out : lvl_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_seq_end;
    sync_fall && have_q && (mode_q == 3'h1);
  endsequence

  a_reset_off: assert property (@(posedge pclk) !presetn |=> !switch_out)
    else $error("output not off after reset");
  a_step_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h0) && step_trig && !step_out |=> step_out [*8])
    else $error("step pulse too short");
  a_minmax_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_seq_end ##0 ((mx_q - mn_q) > ta_q) ##1 (mode_q == 3'h1) |=> switch_out)
    else $error("min max output not raised");
  a_minmax_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_seq_end ##0 ((mx_q - mn_q) <= ta_q) ##1 (mode_q == 3'h1) |=> !switch_out)
    else $error("min max output raised wrongly");
  a_minmax_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h1) && sync_rise ##1 (mode_q == 3'h1) |=> !switch_out)
    else $error("output not cleared at sequence start");
  a_win_outside: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h3) && sample_valid && (sample > ta_q) ##1 (mode_q == 3'h3) |=> switch_out)
    else $error("window output missing");
  a_tol_inside: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h2) && sample_valid && (sample == ta_q) ##1 (mode_q == 3'h2) |=> switch_out)
    else $error("tolerance output missing");
  a_two_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h4) && sync_rise |=> (p1_q == $past(last_q)))
    else $error("first point not captured");
  a_step_small: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == 3'h0) && sample_valid && (step_chg <= half_step) |-> !step_trig)
    else $error("small change raised pulse");

endmodule
`default_nettype wire

// File: logic/diff_eval_pkg.sv
// Purpose: constants and types shared by the distance difference evaluator
// Assumes: distances in micrometres, 16 bit unsigned samples
// Notes: register map lives at the APB slave in the main file
//
// Summary of operation
// - step mode compares samples over 5 ms window
// - step above half taught emits 10 ms pulse
// - change below half returns output inactive
// - small fluctuations never raise a pulse
// - taught step height at least 0,2 mm
// - min/max collects only while sync active
// - sequence end computes max minus min
// - output on when spread exceeds nominal
// - output held until next sequence start
// - spread below nominal keeps output off
// - tolerance mode tests every sample continuously
// - tolerance output active between both bounds
// - nominal and tolerance taught separately
// - window mode stores upper and lower limit
// - window output active outside limits
// - window width at least 0,45 mm
// - two-point captures on sync rise, fall
// - difference above deviation sets output
// - taught deviation at least 0,3 mm
package diff_eval_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WINDOW_US = 5000; // step evaluation window
  localparam int unsigned PULSE_US = 10000; // least output pulse
  // longest time and least time both round down
  localparam int unsigned WINDOW_CYC = (WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000_000) + 0);

  // ---------------------------------------------------------------
  // teach minima in micrometres
  // ---------------------------------------------------------------
  localparam logic [15:0] MIN_STEP_UM = 16'h00C8; // 0,2 mm
  localparam logic [15:0] MIN_WIN_UM = 16'h01C2; // 0,45 mm
  localparam logic [15:0] MIN_DEV_UM = 16'h012C; // 0,3 mm

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00; // mode select
  localparam logic [7:0] REG_TEACH_A = 8'h04; // step / nominal / upper / deviation
  localparam logic [7:0] REG_TEACH_B = 8'h08; // tolerance / lower
  localparam logic [7:0] REG_STATUS = 8'h0C; // output and teach errors
  localparam logic [7:0] REG_RESULT = 8'h10; // last computed difference
  localparam logic [7:0] REG_SAMPLE = 8'h14; // last sample seen

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] TEACH_A_RST = 16'hFFFF;
  localparam logic [15:0] TEACH_B_RST = 16'h0000;

  // evaluation modes
  typedef enum logic [2:0] {
    MODE_STEP = 3'h0,
    MODE_MINMAX = 3'h1,
    MODE_TOL = 3'h2,
    MODE_WIN = 3'h3,
    MODE_TWOPT = 3'h4
  } mode_t;

endpackage

// File: logic/pulse_stretch.sv
// Purpose: holds a switching output high for a least time
// Assumes: single clock, trigger is a level or a pulse
// Notes: output rises the cycle after trigger, falls when count ends and trigger low
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch #(
  parameter int unsigned CYCLES = 100000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trig,
  output logic out_q
);
  logic [31:0] cnt_q, cnt_d; // remaining hold cycles
  logic out_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (trig && !out_q) begin
      // new event while output is low starts the hold
      cnt_d = CYCLES - 32'd1;
      out_d = 1'b1;
    end else if (cnt_q != 32'd0) begin
      cnt_d = cnt_q - 32'd1;
    end else begin
      out_d = trig; // release once hold is spent and cause gone
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'd0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
endmodule
`default_nettype wire

// File: tb/plc_model.sv
// Purpose: controller side model that frames scans with the sync line
// Assumes: sync_in is a level, active high, changed just after pclk edges
// Notes: hold times cover the three-cycle sync path of the evaluator
`timescale 1ns/1ps
`default_nettype none
module plc_model (
  input wire logic pclk,
  output logic sync_in
);
  // ------------------------------------------------------------
  // sync line: idle low outside sequences
  // ------------------------------------------------------------
  initial sync_in = 1'b0;

  // open a sequence; start is chosen apart from the stop
  task start_seq;
    @(posedge pclk);
    sync_in <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  // close a sequence; long hold so the evaluator sees the edge
  task stop_seq;
    @(posedge pclk);
    sync_in <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the distance difference evaluator
// Assumes: short window 20 and pulse 40 cycles, one wait state on APB
// Notes: outputs checked a few cycles after each sample to let pipes settle
`timescale 1ns/1ps
`default_nettype none
module tb;
  import diff_eval_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] sample = 16'h0000;
  logic sample_valid = 1'b0;
  logic sync_in;
  logic switch_out;
  int bad_count = 0;
  int tests_run = 0;

  always #50 pclk = ~pclk; // 10 MHz

  diff_eval #(.WIN_CYC(20), .PULSE_LEN(40)) diff_eval_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample(sample), .sample_valid(sample_valid), .sync_in(sync_in),
    .switch_out(switch_out));
  plc_model plc_model_i (.pclk(pclk), .sync_in(sync_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one APB transfer; held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // one sample, one-cycle valid strobe
  task smp(input logic [15:0] v);
    @(posedge pclk);
    sample <= v;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask

  // output after the two-cycle evaluation path has settled
  task out_is(input logic exp);
    repeat (4) @(posedge pclk);
    chk({31'h0, switch_out}, {31'h0, exp});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task reset_values;
    logic [31:0] r;
    logic e;
    chk({31'h0, switch_out}, 32'h0);
    rd(REG_MODE, r);
    chk(r, 32'h0);
    rd(REG_TEACH_A, r);
    chk(r, {16'h0, TEACH_A_RST});
    rd(REG_TEACH_B, r);
    chk(r, {16'h0, TEACH_B_RST});
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    // an undefined mode code must leave the step mode selected
    wr(REG_MODE, 32'h0000_0007);
    rd(REG_MODE, r);
    chk(r, 32'h0);
    rd(REG_STATUS, r);
    chk({31'h0, r[0]}, 32'h0);
  endtask

  task window_mode;
    logic [31:0] r;
    wr(REG_MODE, {29'h0, MODE_WIN});
    wr(REG_TEACH_A, 32'h03E8); // upper limit 1000
    wr(REG_TEACH_B, 32'h0258); // lower 600: width 400 is too narrow
    rd(REG_STATUS, r);
    chk({31'h0, r[1]}, 32'h1);
    wr(REG_TEACH_B, 32'h01F4);
    smp(16'h02BC);
    out_is(1'b0);
    smp(16'h04B0);
    out_is(1'b1);
    smp(16'h0190);
    out_is(1'b1);
  endtask

  task tol_mode;
    wr(REG_MODE, {29'h0, MODE_TOL});
    wr(REG_TEACH_B, 32'h0064); // band half-width taught apart
    smp(16'h041A);
    out_is(1'b1);
    smp(16'h04B0);
    out_is(1'b0);
    smp(16'h0383);
    out_is(1'b0);
    smp(16'h0384);
    out_is(1'b1);
  endtask

  // rise then fall of 450 against a taught step of 400
  task step_mode;
    logic [15:0] lv[2];
    int n;
    lv[0] = 16'h05AA;
    lv[1] = 16'h03E8;
    wr(REG_MODE, {29'h0, MODE_STEP});
    wr(REG_TEACH_A, 32'h0190);
    // the reference starts at zero, so the first sample may pulse;
    // let that pulse and the window run out, then reload the reference
    repeat (3) smp(16'h03E8);
    repeat (60) @(posedge pclk);
    smp(16'h03E8);
    smp(16'h047E);
    out_is(1'b0);
    for (int i = 0; i < 2; i++) begin
      smp(lv[i]);
      n = 0;
      while (switch_out !== 1'b1 && n < 10) begin
        @(posedge pclk);
        n++;
      end
      chk({31'h0, switch_out}, 32'h1);
      n = 0;
      while (switch_out === 1'b1 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      chk({31'h0, n >= 40 && n < 300}, 32'h1);
      out_is(1'b0);
    end
  endtask

  task minmax_mode;
    logic [31:0] r;
    wr(REG_MODE, {29'h0, MODE_MINMAX});
    wr(REG_TEACH_A, 32'h012C);
    plc_model_i.start_seq();
    smp(16'h03E8);
    smp(16'h04B0);
    smp(16'h0546);
    plc_model_i.stop_seq();
    out_is(1'b1);
    rd(REG_RESULT, r);
    chk(r, 32'h0000_015E);
    smp(16'h1388); // outside a sequence: must be ignored
    out_is(1'b1);
    rd(REG_SAMPLE, r);
    chk(r, 32'h0000_1388);
    plc_model_i.start_seq();
    chk({31'h0, switch_out}, 32'h0);
    smp(16'h03E8);
    smp(16'h044C);
    plc_model_i.stop_seq();
    out_is(1'b0);
  endtask

  task twopt_mode;
    wr(REG_MODE, {29'h0, MODE_TWOPT});
    smp(16'h03E8);
    plc_model_i.start_seq();
    smp(16'h0578);
    plc_model_i.stop_seq();
    out_is(1'b1);
    smp(16'h03E8);
    plc_model_i.start_seq();
    smp(16'h04B0);
    plc_model_i.stop_seq();
    out_is(1'b0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    window_mode();
    tol_mode();
    step_mode();
    minmax_mode();
    twopt_mode();
    tally_and_finish();
  end
endmodule
`default_nettype wire
